/* File: core/line_mode_front.sv */
// Purpose: RS-485 direction control, IrDA SIR coder/decoder and receive gating
// Assumes: sys_clk is the 16x oversample clock; core inputs are synchronous
// Notes: Registers reached over APB; offsets and fields live in the package
//
// Function
// [R1] Control bit 2 selects half-duplex line mode, bit 1 selects infrared mode.
// [R2] Half-duplex without large-block holds transmit interrupt until shift register empty.
// [R3] Direction rises one bit before first stop bit, stays while data pending.
// [R4] Delay field bits 7:5 sets post-stop hold, only in half-duplex mode.
// [R5] Post-transmission hold spans 0 to 15 bit times.
// [R6] Hold count starts when both empty; holding write cancels it.
// [R7] Large-block: interrupt on threshold cross or empty; else shift-register empty. Code does the latter in half-duplex only.
// [R8] Listen set: data stored, threshold, timeout and error interrupts available.
// [R9] Listen clear, no loopback, half-duplex or infrared: nothing stored, no interrupts.
// [R10] Listen clear in plain mode or loopback: stored, no timeout interrupt.
// [R11] Infrared coder works from 16x clock, one bit at a time.
// [R12] Infrared one is no pulse, zero is one pulse per 16 clocks.
// [R13] Transmit data high keeps infrared output low, pulse counter cleared.
// [R14] Transmit data low gives pulse from 7th to 10th clock of bit.
// [R15] Infrared pulse lasts three 16x clocks, at least 1.6 us.
// [R16] After reset decoded receive is high and decoder counter cleared.
// [R17] Receive falling edge drives decoded output low for 16 clocks.
// [R18] Receive strobe on 8th clock after start edge, then every 16.
// [R19] Positive pulses decode on their trailing falling edge.
// [R20] Plain mode passes data unmodified, direction follows modem control bit.
`timescale 1ns/10ps
module line_mode_front import line_mode_pkg::*; (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Channel core side
    input wire logic core_txd,
    input wire logic tsr_empty,
    input wire logic fifo_empty,
    input wire logic fifo_above_thr,
    input wire logic thr_write,
    input wire logic tx_last_data_bit,
    output logic core_rxd,
    output logic rx_sample_strobe,
    output logic rx_store_en,
    output logic rx_irq_en,
    output logic rx_timeout_en,
    output logic tx_irq,
    // Line side
    input wire logic rx_pin,
    output logic tx_pin,
    output logic line_direction_out
);
    // ==========================================================
    // Register file
    logic [7:0] afc_r, afc_nxt;
    logic [1:0] ctrl_r, ctrl_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
    logic en485, infrared_mode_enable, lg, listen, loopback;
    logic [2:0] direction_hold_delay;
    dir_state_e dir_r, dir_nxt;
    logic [7:0] dly_cnt_r, dly_cnt_nxt;
    logic dir_out_r, dir_out_nxt;
    logic mapped, setup;

    // [R1] Mode select bits
    assign en485 = afc_r[AFC_HALF_DUPLEX];
    assign infrared_mode_enable = afc_r[AFC_INFRARED];
    assign lg = afc_r[AFC_LARGE];
    assign listen = afc_r[AFC_LISTEN];
    assign loopback = ctrl_r[CTRL_LOOPBACK];
    assign direction_hold_delay = afc_r[AFC_DLY_HI:AFC_DLY_LO];
    assign setup = psel && !penable;
    assign mapped = (paddr == OFF_AFC) || (paddr == OFF_CTRL) || (paddr == OFF_STATUS);

    // Decode, read capture in setup, write in access phase
    always_comb begin
        afc_nxt = afc_r;
        ctrl_nxt = ctrl_r;
        prdata_nxt = prdata_r;
        pready_nxt = setup;
        pslverr_nxt = setup && !mapped;
        if (setup && !pwrite) begin
            unique case (paddr)
                OFF_AFC: prdata_nxt = {24'h000000, afc_r};
                OFF_CTRL: prdata_nxt = {30'h0, ctrl_r};
                OFF_STATUS: prdata_nxt = {28'h0000000, rx_store_en, dir_r, dir_out_r};
                default: prdata_nxt = 32'h00000000;
            endcase
        end
        if (psel && penable && pready_r && pwrite) begin
            if (paddr == OFF_AFC) begin
                afc_nxt = pwdata[7:0];
            end
            if (paddr == OFF_CTRL) begin
                ctrl_nxt = pwdata[1:0];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            afc_r <= AFC_RESET;
            ctrl_r <= CTRL_RESET;
            prdata_r <= 32'h00000000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            afc_r <= afc_nxt;
            ctrl_r <= ctrl_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;

    // ==========================================================
    // Direction line control
    logic pending;
    assign pending = !tsr_empty || !fifo_empty;

    // Field widened so 7 maps to 15 bit times
    always_comb begin
        dir_nxt = dir_r;
        dly_cnt_nxt = dly_cnt_r;
        unique case (dir_r)
            DIR_IDLE: begin
                if (en485 && pending) begin
                    dir_nxt = DIR_ARMED;
                end
            end
            // [R3] Raise before first stop bit
            DIR_ARMED: begin
                if (tx_last_data_bit) begin
                    dir_nxt = DIR_HOLD;
                end
            end
            // [R6] Hold count starts when both empty
            DIR_HOLD: begin
                if (!pending) begin
                    dir_nxt = DIR_DRAIN;
                    // [R5] Widened delay, sixteen clocks per bit
                    dly_cnt_nxt = {direction_hold_delay, direction_hold_delay[2], 4'h0};
                end
            end
            // [R4] Count off hold delay
            DIR_DRAIN: begin
                if (thr_write) begin
                    // [R6] Holding write cancels delay
                    dir_nxt = DIR_HOLD;
                end else if (dly_cnt_r == 8'h00) begin
                    dir_nxt = DIR_IDLE;
                end else begin
                    dly_cnt_nxt = dly_cnt_r - 8'h01;
                end
            end
        endcase
        if (!en485) begin
            dir_nxt = DIR_IDLE;
        end
        // [R20] Plain mode follows modem bit
        dir_out_nxt = en485 ? (dir_nxt == DIR_HOLD || dir_nxt == DIR_DRAIN) : ctrl_r[CTRL_MODEM_DIR];
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            dir_r <= DIR_IDLE;
            dly_cnt_r <= 8'h00;
            dir_out_r <= 1'b0;
        end else begin
            dir_r <= dir_nxt;
            dly_cnt_r <= dly_cnt_nxt;
            dir_out_r <= dir_out_nxt;
        end
    end
    assign line_direction_out = dir_out_r;

    // ==========================================================
    // Transmit interrupt pacing
    logic tsr_q, fifo_q, above_q, tx_irq_r, tx_irq_nxt;

    // [R2] [R7] Edge events pick by mode
    always_comb begin
        if (en485 && !lg) begin
            tx_irq_nxt = tsr_empty && !tsr_q;
        end else begin
            tx_irq_nxt = (above_q && !fifo_above_thr) || (fifo_empty && !fifo_q && !above_q);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            tsr_q <= 1'b1;
            fifo_q <= 1'b1;
            above_q <= 1'b0;
            tx_irq_r <= 1'b0;
        end else begin
            tsr_q <= tsr_empty;
            fifo_q <= fifo_empty;
            above_q <= fifo_above_thr;
            tx_irq_r <= tx_irq_nxt;
        end
    end
    assign tx_irq = tx_irq_r;

    // ==========================================================
    // Infrared coder, decoder and receive path
    logic [3:0] enc_cnt_r, enc_cnt_nxt, dec_cnt_r, dec_cnt_nxt, scnt_r, scnt_nxt, sbit_r, sbit_nxt;
    logic tx_pin_r, tx_pin_nxt, rx_prev_r, int_rx_r, int_rx_nxt;
    logic core_rxd_r, core_rxd_nxt, sact_r, sact_nxt, strobe_r, strobe_nxt;
    logic store_r, store_nxt, timeout_r, timeout_nxt;

    always_comb begin
        // [R13] High data clears pulse counter
        // [R11] Count runs on 16x clock
        enc_cnt_nxt = core_txd ? 4'h0 : enc_cnt_r + 4'h1;
        // [R12] [R14] Pulse on clocks 7 to 10
        // [R15] Three-clock pulse width
        if (infrared_mode_enable) begin
            tx_pin_nxt = !loopback && !core_txd && enc_cnt_r >= IR_PULSE_FIRST && enc_cnt_r <= IR_PULSE_LAST;
        end else begin
            // [R20] Plain data passes through
            tx_pin_nxt = loopback || core_txd;
        end
        // [R17] [R19] Falling edge starts low window
        int_rx_nxt = int_rx_r;
        dec_cnt_nxt = dec_cnt_r;
        if (rx_prev_r && !rx_pin) begin
            int_rx_nxt = 1'b0;
            dec_cnt_nxt = 4'h0;
        end else if (!int_rx_r) begin
            dec_cnt_nxt = dec_cnt_r + 4'h1;
            int_rx_nxt = (dec_cnt_r == BIT_CLOCKS_M1);
        end
        core_rxd_nxt = loopback ? core_txd : (infrared_mode_enable ? int_rx_r : rx_pin);
        // [R18] Mid-bit strobe after start edge
        sact_nxt = sact_r;
        scnt_nxt = scnt_r + 4'h1;
        sbit_nxt = sbit_r;
        strobe_nxt = sact_r && scnt_r == STROBE_POINT;
        if (!sact_r && core_rxd_r && !core_rxd_nxt) begin
            sact_nxt = 1'b1;
            scnt_nxt = 4'h1;
            sbit_nxt = 4'h0;
        end else if (strobe_nxt) begin
            sbit_nxt = sbit_r + 4'h1;
            sact_nxt = sbit_r != FRAME_BITS_M1;
        end
        // [R8] [R9] [R10] Receive gating table
        store_nxt = listen || loopback || !(en485 || infrared_mode_enable);
        timeout_nxt = listen;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            // [R16] Decoder idles high, counter clear
            enc_cnt_r <= 4'h0;
            dec_cnt_r <= 4'h0;
            int_rx_r <= 1'b1;
            rx_prev_r <= 1'b1;
            tx_pin_r <= 1'b1;
            core_rxd_r <= 1'b1;
            sact_r <= 1'b0;
            scnt_r <= 4'h0;
            sbit_r <= 4'h0;
            strobe_r <= 1'b0;
            store_r <= 1'b1;
            timeout_r <= 1'b0;
        end else begin
            enc_cnt_r <= enc_cnt_nxt;
            dec_cnt_r <= dec_cnt_nxt;
            int_rx_r <= int_rx_nxt;
            rx_prev_r <= rx_pin;
            tx_pin_r <= tx_pin_nxt;
            core_rxd_r <= core_rxd_nxt;
            sact_r <= sact_nxt;
            scnt_r <= scnt_nxt;
            sbit_r <= sbit_nxt;
            strobe_r <= strobe_nxt;
            store_r <= store_nxt;
            timeout_r <= timeout_nxt;
        end
    end
    assign tx_pin = tx_pin_r;
    assign core_rxd = core_rxd_r;
    assign rx_sample_strobe = strobe_r;
    assign rx_store_en = store_r;
    assign rx_irq_en = store_r;
    assign rx_timeout_en = timeout_r;

    // ==========================================================
    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    a_ir_idle_low: assert property (infrared_mode_enable && $past(infrared_mode_enable) && !loopback && $past(core_txd) |-> !tx_pin_r) // [R13]
        else $error("infrared output not low while data high");
    a_ir_pulse_width: assert property (infrared_mode_enable && $rose(tx_pin_r) |-> tx_pin_r ##1 tx_pin_r ##1 tx_pin_r ##1 !tx_pin_r) // [R15]
        else $error("infrared pulse not three clocks");
    a_ir_pulse_place: assert property (infrared_mode_enable && $rose(tx_pin_r) |-> enc_cnt_r == 4'h7) // [R14]
        else $error("infrared pulse at wrong clock");
    a_dec_edge_low: assert property (rx_prev_r && !rx_pin |=> !int_rx_r) // [R17]
        else $error("decoder missed falling edge");
    a_dec_window: assert property ($rose(int_rx_r) |-> $past(dec_cnt_r) == 4'hf) // [R17]
        else $error("decoded low not sixteen clocks");
    a_strobe_mid: assert property (!sact_r && core_rxd_r && !core_rxd_nxt |-> ##8 strobe_r) // [R18]
        else $error("strobe not on eighth clock");
    a_rx_gate_off: assert property ($past(en485 || infrared_mode_enable) && !$past(listen || loopback) |-> !rx_store_en) // [R9]
        else $error("receive stored while disabled");
    a_timeout_off: assert property (!$past(listen) |-> !rx_timeout_en) // [R10]
        else $error("timeout offered with listen clear");
    a_dir_cancel: assert property (dir_r == DIR_DRAIN && thr_write && en485 |=> dir_r == DIR_HOLD) // [R6]
        else $error("holding write did not cancel delay");
    a_dir_held: assert property (en485 && dir_r == DIR_HOLD |=> line_direction_out) // [R3]
        else $error("direction dropped while data pending");
    a_irq_small_block: assert property ($past(en485 && !lg) && tx_irq |-> $past(tsr_empty)) // [R2]
        else $error("transmit interrupt before shift register empty");
    c_dir_cycle: cover property (dir_r == DIR_DRAIN ##1 dir_r == DIR_IDLE);
    c_ir_pulse: cover property (infrared_mode_enable && $rose(tx_pin_r));
    c_strobe: cover property (strobe_r);
    c_cancel: cover property (dir_r == DIR_DRAIN && thr_write);
endmodule : line_mode_front

/* File: core/line_mode_pkg.sv */
// Purpose: Shared constants for the serial line-mode front end
// Assumes: One 32-bit APB word per register, sys_clk is the 16x clock
// Notes: Field positions refer to the alternate-function and control words
package line_mode_pkg;
    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] OFF_AFC = 8'h00;
    localparam logic [7:0] OFF_CTRL = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    // ==========================================================
    // Alternate-function control fields
    localparam int AFC_DLY_HI = 7;
    localparam int AFC_DLY_LO = 5;
    localparam int AFC_LISTEN = 4;
    localparam int AFC_LARGE = 3;
    localparam int AFC_HALF_DUPLEX = 2;
    localparam int AFC_INFRARED = 1;
    localparam logic [7:0] AFC_RESET = 8'h00;
    // ==========================================================
    // Control word fields
    localparam int CTRL_LOOPBACK = 0;
    localparam int CTRL_MODEM_DIR = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    // ==========================================================
    // Timing: one bit time is sixteen oversample clocks
    localparam logic [3:0] BIT_CLOCKS_M1 = 4'hf;
    localparam logic [3:0] IR_PULSE_FIRST = 4'h6;
    localparam logic [3:0] IR_PULSE_LAST = 4'h8;
    localparam logic [3:0] STROBE_POINT = 4'h7;
    localparam logic [3:0] FRAME_BITS_M1 = 4'h9;
    // Direction line state machine
    typedef enum logic [1:0] {
        DIR_IDLE = 2'b00,
        DIR_ARMED = 2'b01,
        DIR_HOLD = 2'b10,
        DIR_DRAIN = 2'b11
    } dir_state_e;
endpackage : line_mode_pkg

/* File: verification/ir_link_model.sv */
// Purpose: Infrared optics stand-in: photodiode source and LED watcher
// Assumes: One bit slot is 16 sys_clk cycles
// Notes: positive selects the pulse polarity seen on rx_pin
`timescale 1ns/10ps
module ir_link_model (
    // Clock
    input wire logic sys_clk,
    // Bench requests
    input wire logic bit_go,
    input wire logic bit_val,
    input wire logic positive,
    // Line side
    input wire logic tx_pin,
    output logic rx_pin,
    output int led_width
);
    // ==========================================================
    // Photodiode slot timing
    int slot = 99;
    int run = 0;
    int width_r = 0;
    logic zero_r = 1'b0;
    assign led_width = width_r;
    always @(posedge sys_clk) begin
        if (bit_go) begin
            slot <= 0;
            zero_r <= !bit_val;
        end else if (slot < 99) begin
            slot <= slot + 1;
        end
    end
    // Idle level is the inverse of the pulse polarity
    assign rx_pin = positive ^ !(zero_r && slot >= 6 && slot <= 8);
    // Width of the last LED pulse seen
    always @(posedge sys_clk) begin
        run <= tx_pin ? run + 1 : 0;
        if (!tx_pin && run > 0) width_r <= run;
    end
endmodule : ir_link_model

/* File: verification/uart_rs485_irda_line_modes_tb.sv */
// Purpose: Self-checking bench for the serial line-mode front end
// Assumes: sys_clk is the 16x clock; APB answers after one access cycle
// Notes: Outputs are read at the clock edge, before that edge's updates land
`timescale 1ns/10ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module uart_rs485_irda_line_modes_tb import line_mode_pkg::*;;
    // ==========================================================
    // Stimulus and observation
    logic sys_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic pready, pslverr, er, core_rxd, rx_sample_strobe, rx_store_en;
    logic rx_irq_en, rx_timeout_en, tx_irq, rx_pin, tx_pin, line_direction_out;
    logic core_txd = 1, tsr_empty = 1, fifo_empty = 1, fifo_above_thr = 0;
    logic thr_write = 0, tx_last_data_bit = 0, bit_go = 0, bit_val = 1, positive = 0;
    logic [9:0] frame = 10'h36a;
    logic [7:0] modes[6] = '{8'h10, 8'h14, 8'h12, 8'h00, 8'h04, 8'h02};
    logic [7:0] im[3] = '{8'h04, 8'h0c, 8'h00};
    int ie[3] = '{1, 2, 2};
    logic [2:0] dl[3] = '{3'd0, 3'd5, 3'd7};
    int led_width, fail_count = 0, n_tests = 0, cyc = 0, irq_n = 0, seed = 81, n, k, d;
    logic q[$];

    line_mode_front dut (.sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .core_txd, .tsr_empty, .fifo_empty, .fifo_above_thr,
        .thr_write, .tx_last_data_bit, .core_rxd, .rx_sample_strobe, .rx_store_en,
        .rx_irq_en, .rx_timeout_en, .tx_irq, .rx_pin, .tx_pin, .line_direction_out);
    ir_link_model optics (.sys_clk, .bit_go, .bit_val, .positive, .tx_pin, .rx_pin, .led_width);

    // 100 MHz clock
    initial forever #5 sys_clk = ~sys_clk;

    // Interrupt count, strobe samples and hang guard
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (tx_irq === 1'b1) irq_n <= irq_n + 1;
        if (rx_sample_strobe === 1'b1) q.push_back(core_rxd);
        if (cyc == 20000) begin
            fail_count++;
            tally_and_finish();
        end
    end

    // ==========================================================
    // Tasks
    task automatic tick(input int c);
        repeat (c) @(posedge sys_clk);
    endtask : tick

    // One APB transfer, held until pready is seen
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        // Only the bench timeout ends a wait for pready
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask : apb

    // One infrared bit slot from the optics
    task automatic ir_bit(input logic v);
        bit_go <= 1'b1;
        bit_val <= v;
        @(posedge sys_clk);
        bit_go <= 1'b0;
        tick(15);
    endtask : ir_bit

    task automatic tally_and_finish();
        $display("comparisons=%0d mismatches=%0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : tally_and_finish

    // ==========================================================
    // Main sequence
    initial begin
        tick(12);
        rst_n <= 1'b1;
        tick(2);
        `CHK({core_rxd, tx_pin, line_direction_out, rx_timeout_en}, 4'b1100)
        apb(0, OFF_AFC, 0);
        `CHK(rd, 32'h0)
        d = $random(seed);
        apb(1, OFF_AFC, d);
        apb(0, OFF_AFC, 0);
        `CHK(rd, {24'h0, d[7:0]})
        apb(0, 8'h0c, 0);
        `CHK({er, rd}, 33'h1_0000_0000)
        // Receive gating over every mode, loopback off and on
        foreach (modes[i]) for (k = 0; k < 2; k++) begin
            apb(1, OFF_AFC, modes[i]);
            apb(1, OFF_CTRL, k);
            tick(1);
            d = modes[i][4] | k | !(modes[i][2] | modes[i][1]);
            `CHK({rx_store_en, rx_irq_en, rx_timeout_en}, {d[0], d[0], modes[i][4]})
        end
        // Plain mode: direction from control, data passed through
        apb(1, OFF_AFC, 0);
        apb(1, OFF_CTRL, 2);
        tick(2);
        `CHK(line_direction_out, 1'b1)
        for (k = 0; k < 16; k++) begin
            d = $random(seed);
            core_txd <= d[0];
            tick(2);
            `CHK(tx_pin, d[0])
        end
        // Loopback: receive follows transmit, line output held idle
        apb(1, OFF_CTRL, 3);
        for (k = 0; k < 8; k++) begin
            d = $random(seed);
            core_txd <= d[0];
            tick(2);
            `CHK({core_rxd, tx_pin}, {d[0], 1'b1})
        end
        core_txd <= 1'b1;
        apb(1, OFF_CTRL, 0);
        // Infrared transmit: two zero bits then idle
        apb(1, OFF_AFC, 8'h02);
        tick(20);
        core_txd <= 1'b0;
        n = 0;
        d = 0;
        for (k = 0; k < 32; k++) begin
            @(posedge sys_clk);
            if (tx_pin === 1'b1) begin
                n++;
                if (d == 0) d = k;
            end
        end
        `CHK(d, 7)
        `CHK(n, 6)
        `CHK(led_width, 3)
        core_txd <= 1'b1;
        tick(2);
        n = 0;
        for (k = 0; k < 16; k++) begin
            @(posedge sys_clk);
            if (tx_pin !== 1'b0) n++;
        end
        `CHK(n, 0)
        // Infrared receive, negative then positive pulses
        apb(1, OFF_AFC, 8'h12);
        for (k = 0; k < 2; k++) begin
            positive <= k[0];
            tick(200);
            q.delete();
            for (d = 0; d < 10; d++) ir_bit(frame[d]);
            tick(40);
            `CHK(q.size(), 10)
            foreach (q[i]) `CHK(q[i], frame[i])
        end
        // Direction line, hold delay and cancel by a holding write
        foreach (dl[i]) begin
            d = {dl[i], dl[i][2]} * 16;
            apb(1, OFF_AFC, {dl[i], 5'h04});
            fifo_empty <= 1'b0;
            tsr_empty <= 1'b0;
            tick(8);
            `CHK(line_direction_out, 1'b0)
            tx_last_data_bit <= 1'b1;
            tick(16);
            tx_last_data_bit <= 1'b0;
            `CHK(line_direction_out, 1'b1)
            // Status: receive gated off, state hold, direction high
            apb(0, OFF_STATUS, 0);
            `CHK(rd, 32'h00000005)
            if (i == 2) begin
                fifo_empty <= 1'b1;
                tsr_empty <= 1'b1;
                tick(20);
                thr_write <= 1'b1;
                fifo_empty <= 1'b0;
                tick(1);
                thr_write <= 1'b0;
                tick(3);
            end
            fifo_empty <= 1'b1;
            tsr_empty <= 1'b1;
            n = 0;
            while (line_direction_out === 1'b1 && n < 400) begin
                @(posedge sys_clk);
                n++;
            end
            `CHK(n >= d && n <= d + 3, 1'b1)
        end
        // Transmit interrupt pacing per mode
        foreach (im[i]) begin
            apb(1, OFF_AFC, im[i]);
            tsr_empty <= 1'b0;
            fifo_empty <= 1'b0;
            fifo_above_thr <= 1'b1;
            tick(4);
            n = irq_n;
            fifo_above_thr <= 1'b0;
            tick(4);
            fifo_empty <= 1'b1;
            tick(4);
            tsr_empty <= 1'b1;
            tick(4);
            `CHK(irq_n - n, ie[i])
        end
        tally_and_finish();
    end
endmodule : uart_rs485_irda_line_modes_tb
